// ### hw/plm_pkg.sv
// Shared constants for the PHY link monitor, reset and TDR control block.
// Assumes a single 10 MHz core clock and a classic Wishbone register bus.
package plm_pkg;
  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam logic [7:0] BASIC_CTRL_ADDR = 8'h00;
  localparam logic [7:0] BASIC_STAT_ADDR = 8'h04;
  localparam logic [7:0] SPECIAL_ADDR = 8'h08;
  localparam logic [7:0] TDR_CS_ADDR = 8'h0c;
  localparam logic [7:0] PHY_CFG_ADDR = 8'h10;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int CTRL_SRST_BIT = 15;
  localparam int CTRL_SPEED_BIT = 13;
  localparam int CTRL_ANEG_BIT = 12;
  localparam int CTRL_PDOWN_BIT = 11;
  localparam int CTRL_DUPLEX_BIT = 8;
  localparam int STAT_LINK_BIT = 2;
  localparam int SPEC_XSTATE_BIT = 13;
  localparam int SPEC_XAUTO_BIT = 15;
  localparam int TDR_EN_BIT = 15;
  localparam int TDR_DONE_BIT = 14;
  localparam int TDR_PAIR_BIT = 13;
  localparam int TDR_LEN_W = 8;
  localparam int CFG_FX_BIT = 0;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [15:0] CTRL_RST = 16'h3100;
  localparam logic [15:0] SPEC_RST = 16'h8000;

  // ****************************************
  // Timing
  // ****************************************
  localparam longint CLK_HZ = 10000000;
  localparam longint STABLE_MS = 330;
  localparam longint STABLE_CYC = (STABLE_MS * CLK_HZ) / 1000;
  localparam longint RESET_US = 102;
  localparam longint RESET_CYC = (RESET_US * CLK_HZ) / 1000000;

  typedef enum logic [1:0] {
    LINK_DOWN = 2'b00,
    LINK_WAIT = 2'b01,
    LINK_READY = 2'b10,
    LINK_UP = 2'b11
  } plm_link_t;

  typedef enum logic [1:0] {
    TDR_IDLE = 2'b00,
    TDR_PULSE = 2'b01,
    TDR_LISTEN = 2'b10,
    TDR_FINISH = 2'b11
  } plm_tdr_t;
endpackage

// ### hw/plm_sync.sv
// Three-stage synchroniser with agreement filter for pin inputs.
// Assumes the input is asynchronous to core_clk.
module plm_sync
  import plm_pkg::*;
#(
  parameter logic RST_VAL = 1'b0
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic pinIn,
  output logic syncOut
);
  logic s1_q;
  logic s2_q;
  logic s3_q;

  // Output changes only when the second and third stages agree
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s1_q <= RST_VAL;
      s2_q <= RST_VAL;
      s3_q <= RST_VAL;
      syncOut <= RST_VAL;
    end else begin
      s1_q <= pinIn;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        syncOut <= s3_q;
      end
    end
  end
endmodule

// ### hw/plm_timer.sv
// Down counter that reports completion after a programmed cycle count.
// Assumes start is a one-cycle pulse from logic on the same clock.
module plm_timer
  import plm_pkg::*;
#(
  parameter int W = 24
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic start,
  input wire logic abort,
  input wire logic [W-1:0] count,
  output logic busy,
  output logic done
);
  logic [W-1:0] cnt_q;

  initial begin
    if (W < 2) $error("plm_timer width too small");
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (abort) begin
        busy <= 1'b0;
      end else if (start) begin
        cnt_q <= count;
        busy <= 1'b1;
      end else if (busy) begin
        if (cnt_q <= W'(1)) begin
          busy <= 1'b0;
          done <= 1'b1;
        end else begin
          cnt_q <= cnt_q - W'(1);
        end
      end
    end
  end
endmodule

// ### hw/plm_top.sv
// PHY control: self reset, power-down reset, link integrity and TDR sequencing.
// Assumes a classic Wishbone master on core_clk and asynchronous DSP/pin levels.
//
// The address map and the Wishbone register port are this design's own decisions.
module plm_top
  import plm_pkg::*;
#(
  parameter longint STABLE_CYCLES = STABLE_CYC,
  parameter int TDR_WINDOW = 255
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic wb_ack_o,
  output logic wb_err_o,
  input wire logic dataValid,
  input wire logic link10Ok,
  input wire logic mode10,
  input wire logic anegGrant,
  input wire logic tdrEcho,
  input wire logic [15:0] strapCtrl,
  output logic phyReset,
  output logic linkLed,
  output logic txRxEnable,
  output logic tdrPulseTx,
  output logic tdrPulseRx
);
  // ****************************************
  // Parameter checks
  // ****************************************
  initial begin
    if (STABLE_CYCLES < 1 || STABLE_CYCLES > 64'hffffff) $error("bad STABLE_CYCLES");
    if (TDR_WINDOW < 2 || TDR_WINDOW > 255) $error("bad TDR_WINDOW");
  end

  // ****************************************
  // Input synchronisers
  // ****************************************
  logic validS;
  logic link10S;
  logic mode10S;
  logic grantS;
  logic echoS;

  plm_sync u_sync_valid (.core_clk(core_clk), .rst(rst), .pinIn(dataValid), .syncOut(validS));
  plm_sync u_sync_l10 (.core_clk(core_clk), .rst(rst), .pinIn(link10Ok), .syncOut(link10S));
  plm_sync u_sync_m10 (.core_clk(core_clk), .rst(rst), .pinIn(mode10), .syncOut(mode10S));
  plm_sync u_sync_gr (.core_clk(core_clk), .rst(rst), .pinIn(anegGrant), .syncOut(grantS));
  plm_sync u_sync_echo (.core_clk(core_clk), .rst(rst), .pinIn(tdrEcho), .syncOut(echoS));

  // ****************************************
  // Registers
  // ****************************************
  logic [15:0] ctrl_q;
  logic [15:0] spec_q;
  logic [TDR_LEN_W-1:0] tdrLen_q;
  logic tdrEn_q;
  logic tdrDone_q;
  logic fxMode_q;
  logic strapLoaded_q;
  logic pdownPrev_q;
  logic ack_q;

  logic busReq;
  logic wrAcc;
  logic rdAcc;
  logic hitCtrl;
  logic hitStat;
  logic hitSpec;
  logic hitTdr;
  logic hitCfg;
  logic mapped;

  // Error answer also closes the request, so err stays a one-cycle pulse
  assign busReq = wb_cyc_i && wb_stb_i && !ack_q && !wb_err_o;
  assign wrAcc = busReq && wb_we_i;
  assign rdAcc = busReq && !wb_we_i;

  // Address decode
  always_comb begin
    hitCtrl = 1'b0;
    hitStat = 1'b0;
    hitSpec = 1'b0;
    hitTdr = 1'b0;
    hitCfg = 1'b0;
    if (wb_adr_i == BASIC_CTRL_ADDR) begin
      hitCtrl = 1'b1;
    end else if (wb_adr_i == BASIC_STAT_ADDR) begin
      hitStat = 1'b1;
    end else if (wb_adr_i == SPECIAL_ADDR) begin
      hitSpec = 1'b1;
    end else if (wb_adr_i == TDR_CS_ADDR) begin
      hitTdr = 1'b1;
    end else if (wb_adr_i == PHY_CFG_ADDR) begin
      hitCfg = 1'b1;
    end
  end
  assign mapped = hitCtrl || hitStat || hitSpec || hitTdr || hitCfg;

  // ****************************************
  // Reset sequencing
  // ****************************************
  logic rstTimerBusy;
  logic rstTimerDone;
  logic rstStart;
  logic pdownExit;
  logic srstWrite;

  assign srstWrite = wrAcc && hitCtrl && wb_sel_i[1] && wb_dat_i[CTRL_SRST_BIT];
  assign pdownExit = pdownPrev_q && !ctrl_q[CTRL_PDOWN_BIT];
  assign rstStart = (srstWrite || pdownExit) && !rstTimerBusy;

  plm_timer #(.W(12)) u_rst_timer (
    .core_clk(core_clk),
    .rst(rst),
    .start(rstStart),
    .abort(1'b0),
    .count(12'(RESET_CYC)),
    .busy(rstTimerBusy),
    .done(rstTimerDone)
  );
  assign phyReset = rstTimerBusy;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pdownPrev_q <= 1'b0;
    end else begin
      pdownPrev_q <= ctrl_q[CTRL_PDOWN_BIT];
    end
  end

  // Control register; straps are caught once after chip reset only
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ctrl_q <= CTRL_RST;
      strapLoaded_q <= 1'b0;
    end else begin
      if (!strapLoaded_q) begin
        ctrl_q <= strapCtrl & ~(16'h1 << CTRL_SRST_BIT);
        strapLoaded_q <= 1'b1;
      end else begin
        if (wrAcc && hitCtrl) begin
          if (wb_sel_i[0]) ctrl_q[7:0] <= wb_dat_i[7:0];
          if (wb_sel_i[1]) ctrl_q[15:8] <= wb_dat_i[15:8];
        end
        // Self reset only clears its own bit; no strap reload or defaults
        // A fresh self-reset request in the finishing cycle keeps its bit
        if (rstTimerDone && !srstWrite) begin
          ctrl_q[CTRL_SRST_BIT] <= 1'b0;
        end
      end
    end
  end

  // Special and config registers hold across power-down and soft reset
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      spec_q <= SPEC_RST;
      fxMode_q <= 1'b0;
    end else begin
      if (wrAcc && hitSpec) begin
        if (wb_sel_i[0]) spec_q[7:0] <= wb_dat_i[7:0];
        if (wb_sel_i[1]) spec_q[15:8] <= wb_dat_i[15:8];
      end
      if (wrAcc && hitCfg && wb_sel_i[0]) begin
        fxMode_q <= wb_dat_i[CFG_FX_BIT];
      end
    end
  end

  // ****************************************
  // Link integrity
  // ****************************************
  plm_link_t link_q;
  logic stableBusy;
  logic stableDone;
  logic stableStart;
  logic linkHold;
  logic link100;
  logic linkSel;

  // Holding link low during reset, power-down or TDR forces Link-Down
  assign linkHold = phyReset || ctrl_q[CTRL_PDOWN_BIT] || tdrEn_q;
  assign stableStart = (link_q == LINK_DOWN) && validS && !linkHold;

  plm_timer #(.W(24)) u_stable_timer (
    .core_clk(core_clk),
    .rst(rst),
    .start(stableStart),
    .abort(!validS || linkHold),
    .count(24'(STABLE_CYCLES)),
    .busy(stableBusy),
    .done(stableDone)
  );

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      link_q <= LINK_DOWN;
    end else if (!validS || linkHold) begin
      link_q <= LINK_DOWN;
    end else begin
      case (link_q)
        LINK_DOWN: begin
          link_q <= LINK_WAIT;
        end
        LINK_WAIT: begin
          // Stability wait applies even with autoneg off
          if (stableDone) begin
            if (ctrl_q[CTRL_ANEG_BIT]) begin
              link_q <= LINK_READY;
            end else begin
              link_q <= LINK_UP;
            end
          end else if (!stableBusy && !stableStart) begin
            link_q <= LINK_DOWN;
          end
        end
        LINK_READY: begin
          if (!ctrl_q[CTRL_ANEG_BIT] || grantS) begin
            link_q <= LINK_UP;
          end
        end
        LINK_UP: begin
          link_q <= LINK_UP;
        end
        default: begin
          link_q <= LINK_DOWN;
        end
      endcase
    end
  end

  assign link100 = (link_q == LINK_UP);
  assign txRxEnable = link100 && !mode10S;
  assign linkSel = mode10S ? (link10S && !linkHold) : link100;
  assign linkLed = linkSel;

  // ****************************************
  // TDR sequencing
  // ****************************************
  plm_tdr_t tdr_q;
  logic [TDR_LEN_W-1:0] tdrCnt_q;
  logic pairCross;
  logic tdrStartWr;

  // Pair choice follows the crossover-state bit when auto crossover is off
  assign pairCross = spec_q[SPEC_XSTATE_BIT] && !spec_q[SPEC_XAUTO_BIT];
  assign tdrStartWr = wrAcc && hitTdr && wb_sel_i[1] && wb_dat_i[TDR_EN_BIT];
  assign tdrPulseTx = (tdr_q == TDR_PULSE) && !pairCross;
  assign tdrPulseRx = (tdr_q == TDR_PULSE) && pairCross;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tdr_q <= TDR_IDLE;
      tdrCnt_q <= '0;
      tdrLen_q <= '0;
      tdrEn_q <= 1'b0;
      tdrDone_q <= 1'b0;
    end else begin
      case (tdr_q)
        TDR_IDLE: begin
          if (tdrStartWr && !fxMode_q) begin
            tdrEn_q <= 1'b1;
            tdrDone_q <= 1'b0;
            tdr_q <= TDR_PULSE;
          end else if (wrAcc && hitTdr && wb_sel_i[1] && !wb_dat_i[TDR_DONE_BIT]) begin
            tdrDone_q <= 1'b0;
          end
        end
        TDR_PULSE: begin
          tdrCnt_q <= '0;
          tdr_q <= TDR_LISTEN;
        end
        TDR_LISTEN: begin
          // No echo inside the window reports full scale (matched line)
          if (echoS || tdrCnt_q == TDR_LEN_W'(TDR_WINDOW)) begin
            tdrLen_q <= tdrCnt_q;
            tdr_q <= TDR_FINISH;
          end else begin
            tdrCnt_q <= tdrCnt_q + TDR_LEN_W'(1);
          end
        end
        TDR_FINISH: begin
          tdrEn_q <= 1'b0;
          tdrDone_q <= 1'b1;
          tdr_q <= TDR_IDLE;
        end
        default: begin
          tdr_q <= TDR_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // Wishbone answer
  // ****************************************
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ack_q <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      ack_q <= busReq && mapped;
      wb_err_o <= busReq && !mapped;
      wb_dat_o <= '0;
      if (rdAcc) begin
        if (hitCtrl) begin
          wb_dat_o <= {16'h0, ctrl_q};
        end else if (hitStat) begin
          wb_dat_o <= 32'(linkSel) << STAT_LINK_BIT;
        end else if (hitSpec) begin
          wb_dat_o <= {16'h0, spec_q};
        end else if (hitTdr) begin
          wb_dat_o <= {16'h0, tdrEn_q, tdrDone_q, pairCross, 5'h0, tdrLen_q};
        end else if (hitCfg) begin
          wb_dat_o <= 32'(fxMode_q);
        end
      end
    end
  end
  assign wb_ack_o = ack_q;
endmodule

// ### bench/plm_partner.sv
// Cable model: reflects every TDR pulse after a chosen delay.
// Assumes the bench sets echoDelay before each test is started.
module plm_partner (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic tdrPulseTx,
  input wire logic tdrPulseRx,
  input wire logic [7:0] echoDelay,
  output logic tdrEcho,
  output logic [7:0] txCnt,
  output logic [7:0] rxCnt
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************
  // Reflection
  // ****************************************
  logic [8:0] dly;
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      dly <= 9'h0;
      tdrEcho <= 1'b0;
      txCnt <= 8'h0;
      rxCnt <= 8'h0;
    end else begin
      // Held four cycles so the pin filter cannot miss it
      tdrEcho <= (dly != 9'h0) && (dly <= 9'h4);
      if (tdrPulseTx) txCnt <= txCnt + 8'h1;
      if (tdrPulseRx) rxCnt <= rxCnt + 8'h1;
      if (tdrPulseTx || tdrPulseRx) begin
        dly <= {1'b0, echoDelay} + 9'h4;
      end else if (dly != 9'h0) begin
        dly <= dly - 9'h1;
      end
    end
  end
endmodule

// ### bench/plm_chk.sv
// Port checker for plm_top, bound onto every instance.
// Assumes STABLE_CYCLES is handed on from the instance.
module plm_chk
  import plm_pkg::*;
#(
  parameter longint STABLE_CYCLES = 50
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic wb_err_o,
  input wire logic dataValid,
  input wire logic mode10,
  input wire logic linkLed,
  input wire logic txRxEnable,
  input wire logic tdrPulseTx,
  input wire logic tdrPulseRx,
  input wire logic phyReset
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************
  // Helpers and properties
  // ****************************************
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  logic [10:0] rstLen_q;
  longint validLen_q;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rstLen_q <= 11'h0;
      validLen_q <= 64'h0;
    end else begin
      rstLen_q <= phyReset ? rstLen_q + 11'h1 : 11'h0;
      // Saturates so a long link cannot wrap the count
      if (!dataValid) validLen_q <= 64'h0;
      else if (validLen_q < STABLE_CYCLES) validLen_q <= validLen_q + 64'h1;
    end
  end
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  endsequence
  sequence s_pulse;
    tdrPulseTx || tdrPulseRx;
  endsequence
  a_bus_answer: assert property (s_req |=> wb_ack_o || wb_err_o)
    else $error("bus request left unanswered");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_err_pulse: assert property (wb_err_o |=> !wb_err_o)
    else $error("err longer than one cycle");
  a_ack_err_excl: assert property (!(wb_ack_o && wb_err_o))
    else $error("ack and err together");
  a_link_drop: assert property ((!dataValid && !mode10) [*7] |-> !linkLed)
    else $error("link kept after line invalid");
  a_stable_wait: assert property ($rose(linkLed) && !mode10 |-> validLen_q >= STABLE_CYCLES)
    else $error("link rose before stable wait");
  a_txrx_up: assert property (txRxEnable |-> linkLed && !mode10)
    else $error("tx rx enabled without link up");
  a_pulse_one: assert property (s_pulse |-> !(tdrPulseTx && tdrPulseRx) ##1 !(tdrPulseTx || tdrPulseRx))
    else $error("bad tdr pulse shape");
  a_tdr_no_link: assert property (s_pulse |=> !txRxEnable && !linkLed)
    else $error("link active during tdr");
  a_reset_len: assert property ($fell(phyReset) |-> rstLen_q == 11'h3fc)
    else $error("phy reset length wrong");
endmodule

bind plm_top plm_chk #(.STABLE_CYCLES(STABLE_CYCLES)) i_plm_chk (
  .core_clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .wb_err_o, .dataValid, .mode10,
  .linkLed, .txRxEnable, .tdrPulseTx, .tdrPulseRx, .phyReset);

// ### bench/tb_top.sv
// Testbench for plm_top: register, link and cable test sequences.
// Assumes the cable model in plm_partner and a shortened stable wait.
`define CHK(nm, ex, got) begin \
  samples_checked++; \
  if ((got) !== (ex)) begin \
    fails++; \
    $display("unexpected %s expected %h seen %h", nm, ex, got); \
  end \
end
module tb_top
  import plm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam longint STB = 50;
  logic core_clk, rst, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o, wb_err_o, er;
  logic [7:0] wb_adr_i, echoDelay, txCnt, rxCnt, len1;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic [3:0] wb_sel_i;
  logic dataValid, link10Ok, mode10, anegGrant, tdrEcho;
  logic phyReset, linkLed, txRxEnable, tdrPulseTx, tdrPulseRx;
  logic [15:0] strapCtrl, rd;
  int fails, samples_checked, n;

  plm_top #(.STABLE_CYCLES(STB), .TDR_WINDOW(20)) i_plm_top (
    .core_clk, .rst, .wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_we_i, .wb_sel_i, .wb_cyc_i,
    .wb_stb_i, .wb_ack_o, .wb_err_o, .dataValid, .link10Ok, .mode10, .anegGrant, .tdrEcho,
    .strapCtrl, .phyReset, .linkLed, .txRxEnable, .tdrPulseTx, .tdrPulseRx);
  plm_partner i_plm_partner (
    .core_clk, .rst, .tdrPulseTx, .tdrPulseRx, .echoDelay, .tdrEcho, .txCnt, .rxCnt);

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic final_report;
    if (fails == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // Entered just after a rising edge; holds the request until ack or err
  task automatic bus(input logic [7:0] a, input logic we, input logic [15:0] d);
    int k;
    wb_adr_i <= a;
    wb_we_i <= we;
    wb_sel_i <= 4'h3;
    wb_dat_i <= {16'h0, d};
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && k < 20);
    rd = wb_dat_o[15:0];
    er = wb_err_o;
    if (k >= 20) begin
      fails++;
      final_report();
    end
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge core_clk);
  endtask

  function automatic logic pick(input int w);
    logic [2:0] v;
    v = {txRxEnable, phyReset, linkLed};
    return v[w];
  endfunction

  task automatic wait_sig(input int w, input logic want, input int lim);
    n = 0;
    while (pick(w) !== want && n < lim) begin
      @(posedge core_clk);
      n++;
    end
    if (n >= lim) begin
      fails++;
      final_report();
    end
  endtask

  task automatic tdr_run;
    int k;
    bus(TDR_CS_ADDR, 1'b1, 16'h8000);
    k = 0;
    do begin
      bus(TDR_CS_ADDR, 1'b0, 16'h0);
      k++;
    end while (rd[TDR_DONE_BIT] !== 1'b1 && k < 40);
    if (k >= 40) begin
      fails++;
      final_report();
    end
  endtask

  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    {rst, wb_we_i, wb_cyc_i, wb_stb_i, dataValid, link10Ok, mode10, anegGrant} = 8'h80;
    wb_adr_i = 8'h0;
    wb_dat_i = 32'h0;
    wb_sel_i = 4'h3;
    strapCtrl = 16'hb100;
    echoDelay = 8'h5;
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    repeat (2) @(posedge core_clk);
    bus(BASIC_CTRL_ADDR, 1'b0, 16'h0);
    `CHK("ctrlStrap", 16'h3100, rd)
    bus(8'h40, 1'b0, 16'h0);
    `CHK("unmapped", 1'b1, er)
    bus(BASIC_CTRL_ADDR, 1'b1, 16'ha100);
    wait_sig(1, 1'b1, 10);
    wait_sig(1, 1'b0, 1100);
    bus(BASIC_CTRL_ADDR, 1'b0, 16'h0);
    `CHK("ctrlSelfClr", 16'h2100, rd)
    bus(BASIC_CTRL_ADDR, 1'b1, 16'h2900);
    bus(BASIC_CTRL_ADDR, 1'b0, 16'h0);
    `CHK("ctrlPdown", 16'h2900, rd)
    bus(BASIC_CTRL_ADDR, 1'b1, 16'h2100);
    wait_sig(1, 1'b1, 10);
    wait_sig(1, 1'b0, 1100);
    bus(BASIC_CTRL_ADDR, 1'b0, 16'h0);
    `CHK("ctrlWake", 16'h2100, rd)
    dataValid <= 1'b1;
    wait_sig(0, 1'b1, STB + 20);
    `CHK("stableWait", 1'b1, n >= STB)
    `CHK("txRxUp", 1'b1, txRxEnable)
    bus(BASIC_STAT_ADDR, 1'b0, 16'h0);
    `CHK("statLink", 1'b1, rd[STAT_LINK_BIT])
    bus(SPECIAL_ADDR, 1'b1, 16'h0000);
    bus(PHY_CFG_ADDR, 1'b1, 16'h0001);
    bus(PHY_CFG_ADDR, 1'b0, 16'h0);
    `CHK("fxMode", 1'b1, rd[CFG_FX_BIT])
    bus(TDR_CS_ADDR, 1'b1, 16'h8000);
    bus(TDR_CS_ADDR, 1'b0, 16'h0);
    `CHK("fxNoTdr", 1'b0, rd[TDR_EN_BIT])
    bus(PHY_CFG_ADDR, 1'b1, 16'h0000);
    tdr_run();
    len1 = rd[7:0];
    `CHK("txPulses", 8'h01, txCnt)
    `CHK("rxPulses", 8'h00, rxCnt)
    echoDelay <= 8'h9;
    tdr_run();
    `CHK("lenDiff", 8'h04, 8'(rd[7:0] - len1))
    bus(SPECIAL_ADDR, 1'b1, 16'h2000);
    tdr_run();
    `CHK("rxPulses", 8'h01, rxCnt)
    `CHK("pairBit", 1'b1, rd[TDR_PAIR_BIT])
    bus(SPECIAL_ADDR, 1'b1, 16'h8000);
    bus(BASIC_CTRL_ADDR, 1'b1, 16'h3100);
    repeat (STB + 30) @(posedge core_clk);
    `CHK("readyWait", 1'b0, txRxEnable)
    anegGrant <= 1'b1;
    wait_sig(2, 1'b1, 10);
    dataValid <= 1'b0;
    wait_sig(0, 1'b0, 7);
    `CHK("txRxDown", 1'b0, txRxEnable)
    mode10 <= 1'b1;
    link10Ok <= 1'b1;
    wait_sig(0, 1'b1, 8);
    bus(BASIC_STAT_ADDR, 1'b0, 16'h0);
    `CHK("statLink10", 1'b1, rd[STAT_LINK_BIT])
    link10Ok <= 1'b0;
    wait_sig(0, 1'b0, 8);
    final_report();
  end

  initial begin
    repeat (50000) @(posedge core_clk);
    fails++;
    final_report();
  end
endmodule
